// >>> rtl/oscst_pkg.sv
// Package with register map, field positions and reset values of the oscillator status block
package oscst_pkg;

  // Register byte offsets on APB
  localparam logic [11:0] OSCST_STATUS_OFF   = 12'h000;
  localparam logic [11:0] OSCST_EVT_OFF      = 12'h004;
  localparam logic [11:0] OSCST_MASK_OFF     = 12'h008;

  // Field positions of the status register
  localparam int OSCST_POS_UNUSED   = 7;
  localparam int OSCST_POS_MULT_RDY = 6;
  localparam int OSCST_POS_STARTUP  = 5;
  localparam int OSCST_POS_HF_RDY   = 4;
  localparam int OSCST_POS_HF_LOCK  = 3;
  localparam int OSCST_POS_MF_RDY   = 2;
  localparam int OSCST_POS_LF_RDY   = 1;
  localparam int OSCST_POS_HF_STAB  = 0;

  // Reset values
  localparam logic [7:0]  OSCST_STATUS_RST   = 8'h00;
  localparam logic [7:0]  OSCST_EVT_RST      = 8'h00;
  localparam logic [7:0]  OSCST_MASK_RST     = 8'h00;
  localparam logic [31:0] OSCST_RDATA_RST    = 32'h0000_0000;

  // Implemented bits of the status layout; bit 7 reads zero
  localparam logic [7:0]  OSCST_IMPL_MASK    = 8'h7f;

  // Synchroniser depth
  localparam int OSCST_SYNC_STAGES = 3;

  // Hardware flag inputs, grouped
  typedef struct packed {
    logic mult_ready;
    logic startup_timer_state;
    logic hf_osc_ready;
    logic hf_osc_locked;
    logic mf_osc_ready;
    logic lf_osc_ready;
    logic hf_osc_stable;
  } oscst_flags_t;

endpackage

// >>> rtl/oscst_sync.sv
// Three-stage synchroniser with agreement filter for one asynchronous flag
`timescale 1ns/100ps
`default_nettype none
module oscst_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic async_in,
  output var  logic level_out
);
  import oscst_pkg::*;

  logic [OSCST_SYNC_STAGES-1:0] stage_r;
  logic                         level_r;

  // A change is accepted only once stages two and three agree
  wire agree = (stage_r[1] == stage_r[2]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_r <= '0;
      level_r <= 1'b0;
    end else begin
      stage_r <= {stage_r[1:0], async_in};
      if (agree) begin
        level_r <= stage_r[2];
      end
    end
  end

  assign level_out = level_r;
endmodule
`default_nettype wire

// >>> rtl/oscst_top.sv
// APB status register reporting oscillator, multiplier and start-up timer flags
//
// Contract
// - Bit 7 of the status register always reads zero.
// - Bit 5 reads one when running from the configured clock source.
// - Bit 4 reads one when the high-frequency oscillator is ready.
// - Bit 3 reads one when the high-frequency oscillator is within 2 percent.
// - Bit 2 reads one when the medium-frequency oscillator is ready.
// - Bit 1 reads one when the low-frequency oscillator is ready.
// - Bit 0 reads one when the high-frequency oscillator is within 0.5 percent.
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module oscst_top (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output var  logic [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire oscst_pkg::oscst_flags_t hw_flags,
  output logic                        irq
);
  import oscst_pkg::*;

  // Flags come from other clock domains, so each is synchronised
  logic [6:0] raw_flags;
  logic [6:0] sync_flags;
  assign raw_flags = hw_flags;

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_sync
      oscst_sync u_sync (
        .pclk      (pclk),
        .presetn   (presetn),
        .async_in  (raw_flags[gi]),
        .level_out (sync_flags[gi])
      );
    end
  endgenerate

  // Status view; bit 7 is unimplemented
  wire [7:0] status_view = {1'b0, sync_flags} & OSCST_IMPL_MASK;

  // Field mapping, kept explicit for clarity of bit positions
  wire mult_rdy_bit = status_view[OSCST_POS_MULT_RDY];
  wire startup_bit  = status_view[OSCST_POS_STARTUP];
  wire hf_rdy_bit   = status_view[OSCST_POS_HF_RDY];
  wire hf_lock_bit  = status_view[OSCST_POS_HF_LOCK];
  wire mf_rdy_bit   = status_view[OSCST_POS_MF_RDY];
  wire lf_rdy_bit   = status_view[OSCST_POS_LF_RDY];
  wire hf_stab_bit  = status_view[OSCST_POS_HF_STAB];
  wire [7:0] status_word = {1'b0, mult_rdy_bit, startup_bit, hf_rdy_bit,
                            hf_lock_bit, mf_rdy_bit, lf_rdy_bit, hf_stab_bit};

  // Change detection: any toggle of a flag is an event
  logic [7:0] prev_r;
  wire  [7:0] change = status_word ^ prev_r;

  // APB decode
  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  wire acc       = psel & penable;
  wire wr_acc    = acc & pwrite;
  wire hit_stat  = addr_hit(paddr, OSCST_STATUS_OFF);
  wire hit_evt   = addr_hit(paddr, OSCST_EVT_OFF);
  wire hit_mask  = addr_hit(paddr, OSCST_MASK_OFF);
  wire mapped    = hit_stat | hit_evt | hit_mask;
  wire lane0     = pstrb[0];

  // Status is read only; a write there is silently dropped
  wire wr_evt    = wr_acc & hit_evt & lane0;
  wire wr_mask   = wr_acc & hit_mask & lane0;

  logic [7:0] evt_r;
  logic [7:0] evt_nxt;
  logic [7:0] mask_r;

  // Set wins over write-one-to-clear in the same cycle
  assign evt_nxt = (evt_r & ~(wr_evt ? pwdata[7:0] : 8'h00)) | change;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= OSCST_STATUS_RST;
      evt_r  <= OSCST_EVT_RST;
      mask_r <= OSCST_MASK_RST;
    end else begin
      prev_r <= status_word;
      evt_r  <= evt_nxt & OSCST_IMPL_MASK;
      if (wr_mask) begin
        mask_r <= pwdata[7:0] & OSCST_IMPL_MASK;
      end
    end
  end

  // Read data registered at the setup phase so it is valid in the access phase
  wire        setup   = psel & ~penable & ~pwrite;
  wire [7:0]  rd_sel  = hit_stat ? status_word :
                        hit_evt  ? evt_r :
                        hit_mask ? mask_r : 8'h00;
  logic [31:0] rdata_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r <= OSCST_RDATA_RST;
    end else if (setup) begin
      rdata_r <= {24'h00_0000, rd_sel};
    end
  end

  assign prdata  = rdata_r;
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;
  assign irq     = |(evt_r & mask_r);
endmodule
`default_nettype wire

// >>> dv/oscst_sva.sv
// Checker of the oscillator status register port behaviour
`timescale 1ns/100ps
`default_nettype none
module oscst_sva (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [11:0]             paddr,
  input wire logic [31:0]             prdata,
  input wire logic                    pslverr,
  input wire logic                    irq,
  input wire oscst_pkg::oscst_flags_t hw_flags
);
  import oscst_pkg::*;
  logic [6:0] f;
  logic [6:0] fq;
  logic [2:0] st;
  assign f = hw_flags;
  // Only judge status reads once the flags have settled through the synchroniser
  // Only a read setup loads the read register, so writes are left out here
  wire ok = psel && !penable && !pwrite && paddr == OSCST_STATUS_OFF && st == 3'd7;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) {fq, st} <= '0;
    else {fq, st} <= {f, (f != fq) ? 3'd0 : st + {2'b0, st != 3'd7}};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_top_bit_zero: assert property (psel && penable && !pwrite |-> prdata[7] == 1'b0) else $error("bit 7 set");
  a_mult_ready: assert property (ok |=> prdata[6] == $past(f[6])) else $error("bit 6 wrong");
  a_startup_state: assert property (ok |=> prdata[5] == $past(f[5])) else $error("bit 5 wrong");
  a_hf_ready: assert property (ok |=> prdata[4] == $past(f[4])) else $error("bit 4 wrong");
  a_hf_locked: assert property (ok |=> prdata[3] == $past(f[3])) else $error("bit 3 wrong");
  a_mf_ready: assert property (ok |=> prdata[2] == $past(f[2])) else $error("bit 2 wrong");
  a_lf_ready: assert property (ok |=> prdata[1] == $past(f[1])) else $error("bit 1 wrong");
  a_hf_stable: assert property (ok |=> prdata[0] == $past(f[0])) else $error("bit 0 wrong");
  a_status_write_void: assert property (psel && penable && pwrite && paddr == OSCST_STATUS_OFF && st == 3'd7
    |-> !pslverr ##1 $stable(irq)) else $error("status write had effect");
endmodule
bind oscst_top oscst_sva oscst_sva_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .irq(irq), .hw_flags(hw_flags));
`default_nettype wire

// >>> dv/test_oscillator_status_flags.sv
// Self-checking bench of the oscillator status register
`timescale 1ns/100ps
`default_nettype none
module test_oscillator_status_flags;
  import oscst_pkg::*;
  logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, err;
  logic [11:0]  paddr = '0;
  logic [31:0]  pwdata = '0, prdata, rd;
  logic [3:0]   pstrb = 4'hf;
  oscst_flags_t hw_flags = '0;
  int           n_errors = 0, comparisons = 0;
  oscst_top oscst_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hw_flags(hw_flags), .irq(irq));
  always #5 pclk = ~pclk;
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h0c25));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    $display("reset values done");
    // Walking ones first, so every flag and every event bit is exercised
    for (int i = 0; i < 24; i++) begin
      hw_flags <= 7'(i < 7 ? 32'h1 << i : $urandom);
      repeat (8) @(posedge pclk);
      apb(1'b1, OSCST_STATUS_OFF, 32'hffff_ffff);
      apb(1'b0, OSCST_STATUS_OFF, 32'h0);
      chk(rd, {25'h0, hw_flags});
    end
    $display("flag reads done");
    apb(1'b1, OSCST_MASK_OFF, 32'hff);
    apb(1'b0, OSCST_MASK_OFF, 32'h0);
    chk(rd, 32'h7f);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, OSCST_EVT_OFF, 32'hff);
    apb(1'b1, OSCST_MASK_OFF, 32'h0);
    apb(1'b0, OSCST_EVT_OFF, 32'h0);
    chk(rd, 32'h0);
    hw_flags <= hw_flags ^ 7'h01;
    repeat (8) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, OSCST_MASK_OFF, 32'h01);
    apb(1'b0, OSCST_EVT_OFF, 32'h0);
    chk(rd, 32'h01);
    chk({31'h0, irq}, 32'h1);
    // A write without byte lane 0 must leave the mask as it was
    pstrb <= 4'he;
    apb(1'b1, OSCST_MASK_OFF, 32'h7f);
    pstrb <= 4'hf;
    apb(1'b0, OSCST_MASK_OFF, 32'h0);
    chk(rd, 32'h01);
    apb(1'b0, 12'h00c, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    $display("interrupt and unmapped done");
    give_verdict();
  end
  initial begin
    #50000;
    n_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
